// *** iop_pkg.sv ***
// Shared constants and types of the general-purpose port group.
// Assumes word-wide register access where a register index maps to byte address index * 4.
package iop_pkg;

    // Register indices; the byte address is the index shifted left by two.
    localparam int          ADDR_LSB        = 2;
    localparam logic [15:0] IDX_FIRST_DATA  = 16'hFF00;
    localparam logic [15:0] IDX_INPUT_DATA  = 16'hFF01;
    localparam logic [15:0] IDX_OUTPUT_DATA = 16'hFF02;
    localparam logic [15:0] IDX_SECOND_DATA = 16'hFF03;
    localparam logic [15:0] IDX_SEGA_DATA   = 16'hFF08;
    localparam logic [15:0] IDX_SEGB_DATA   = 16'hFF09;
    localparam logic [15:0] IDX_FIRST_DIR   = 16'hFF20;
    localparam logic [15:0] IDX_OUT_TRI     = 16'hFF22;
    localparam logic [15:0] IDX_SECOND_DIR  = 16'hFF23;
    localparam logic [15:0] IDX_SEGA_DIR    = 16'hFF28;
    localparam logic [15:0] IDX_SEGB_DIR    = 16'hFF29;
    localparam logic [15:0] IDX_FIRST_PU    = 16'hFF30;
    localparam logic [15:0] IDX_SECOND_PU   = 16'hFF33;
    localparam logic [15:0] IDX_SEGA_PU     = 16'hFF38;
    localparam logic [15:0] IDX_SEGB_PU     = 16'hFF39;
    localparam logic [15:0] IDX_SECOND_FUNC = 16'hFF43;
    localparam logic [15:0] IDX_SEGA_FUNC   = 16'hFF48;
    localparam logic [15:0] IDX_DISP_CTRL   = 16'hFF49;

    // Reset values.
    localparam logic [7:0] DIR_RST   = 8'hFF;
    localparam logic [7:0] LATCH_RST = 8'h00;
    localparam logic [7:0] PU_RST    = 8'h00;
    localparam logic [7:0] FUNC_RST  = 8'h00;

    // Which bit positions carry a pin in each port.
    localparam logic [7:0] FIRST_MASK  = 8'h0F;
    localparam logic [7:0] SECOND_MASK = 8'hF0;
    localparam logic [7:0] FULL_MASK   = 8'hFF;
    localparam logic [4:0] INPUT_MASK  = 5'h1F;

    // Pin of the first port that doubles as the network controller clock.
    localparam int NETC_CLK_BIT = 0;

    // Bus-side states, Gray coded along idle, write, read wait, read done.
    typedef enum logic [1:0] {
        ST_IDLE    = 2'b00,
        ST_WR      = 2'b01,
        ST_RD_WAIT = 2'b11,
        ST_RD_DONE = 2'b10
    } iop_bus_st_t;

    // Drive of one port's pads.
    typedef struct packed {
        logic [7:0] out;
        logic [7:0] oe;
        logic [7:0] pu;
    } iop_pad_t;

endpackage

// *** iop_bidir_port.sv ***
// Per-pin drive, pull-up and read-back logic of one bidirectional port.
// Assumes registered control inputs; the caller registers the pad drive.
`timescale 1ns/1ps
module iop_bidir_port import iop_pkg::*; #(
    parameter logic [7:0] PIN_MASK = 8'hFF
) (
    // Control state of the port.
    input  wire logic [7:0] latch,
    input  wire logic [7:0] dir,
    input  wire logic [7:0] pu_en,
    input  wire logic [7:0] seg_sel,
    // Alternate sources.
    input  wire logic [7:0] seg_val,
    input  wire logic [7:0] alt_en,
    input  wire logic [7:0] alt_val,
    // Pin side.
    input  wire logic [7:0] pin_in,
    output iop_pad_t        pad,
    output logic [7:0]      rd_val
);

    wire [7:0] out_w;
    wire [7:0] oe_w;
    wire [7:0] pu_w;
    wire [7:0] rd_w;

    // Each pin is decided on its own; bits without a pin never drive.
    for (genvar i = 0; i < 8; i++) begin : g_bit
        // A set alternate source is ORed onto the latch, so a latch left high masks it.
        assign out_w[i] = seg_sel[i] ? seg_val[i] :
                          (alt_en[i] ? (latch[i] | alt_val[i]) : latch[i]); // see R12
        assign oe_w[i]  = PIN_MASK[i] & (seg_sel[i] | ~dir[i]); // see R20
        assign pu_w[i]  = PIN_MASK[i] & dir[i] & pu_en[i] & ~seg_sel[i]; // see R2
        assign rd_w[i]  = PIN_MASK[i] & (dir[i] ? pin_in[i] : latch[i]); // see R22
    end

    // Gather the bits into the carrier.
    assign pad    = '{out: out_w, oe: oe_w, pu: pu_w};
    assign rd_val = rd_w;

endmodule

// *** iop_port_group.sv ***
// General-purpose port group: register file on AHB-Lite for six ports and pad drive of five of them.
// Assumes pin inputs synchronous to clk_sys and a single AHB-Lite master.
//
// Notes on behaviour
// R1 - First bidirectional port: four pins, latch and per-pin direction bit each.
// R2 - Pull-up on a first-port pin only in input mode with its pull-up bit set.
// R3 - Reset puts every first-port pin in input mode.
// R4 - First-port pins feed external interrupt inputs and network controller clock.
// R5 - A first-port pin in output mode raises its interrupt request when level changes.
// R6 - Software masks the interrupt before using first-port pins as outputs.
// R7 - Five input-only pins, read through the port, no latch, also analog inputs.
// R8 - Eight output-only pins with latches; mode bit one puts the pin in high impedance.
// R9 - Reset puts every output-only pin in high impedance.
// R10 - Output port read returns the latch when mode bit is one, zero otherwise.
// R11 - Output-only pins can carry the meter pulse-width outputs.
// R12 - Software clears the latch before an alternate function drives the pin.
// R13 - Software disables the alternate function to drive the latch value.
// R14 - Second bidirectional port: four pins, latch, direction and input pull-ups.
// R15 - Reset puts every second-port pin in input mode.
// R16 - Software selects segment function before using second-port pins as segments.
// R17 - Eight-pin port A: per-pin direction, input pull-ups, input mode after reset.
// R18 - Port A picks segment output or I/O per pin from its function register.
// R19 - Port B picks segment or I/O per pin from display control; input after reset.
// R20 - Direction bit zero enables the output buffer, one leaves input mode.
// R21 - Reset loads every direction register with all ones.
// R22 - Bidirectional read returns pin level in input mode, latch in output mode.
// R23 - A port write updates its latch whatever the direction.
`timescale 1ns/1ps
module iop_port_group import iop_pkg::*; (
    // Clock and reset.
    input  wire logic        clk_sys,
    input  wire logic        srst,
    // AHB-Lite slave.
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic             hreadyout,
    output logic [31:0]      hrdata,
    output logic             hresp,
    // First bidirectional port, bits 3:0.
    input  wire logic [7:0]  first_bidir_pins_in,
    output iop_pad_t         first_bidir_pad,
    output logic [3:0]       ext_int_level,
    output logic [3:0]       ext_int_req,
    output logic             netc_ext_clk,
    // Input-only port.
    input  wire logic [4:0]  input_only_pins,
    // Output-only port and meter pulse-width sources.
    output iop_pad_t         output_only_pad,
    input  wire logic [7:0]  pwm_en,
    input  wire logic [7:0]  pwm_val,
    // Second bidirectional port, bits 7:4, with timer and serial outputs.
    input  wire logic [7:0]  second_bidir_pins_in,
    output iop_pad_t         second_bidir_pad,
    input  wire logic [7:0]  second_alt_en,
    input  wire logic [7:0]  second_alt_val,
    input  wire logic [7:0]  segment_outputs_c,
    // Segment-capable ports A and B.
    input  wire logic [7:0]  segment_bidir_pins_a_in,
    output iop_pad_t         segment_bidir_pad_a,
    input  wire logic [7:0]  segment_outputs_a,
    input  wire logic [7:0]  segment_bidir_pins_b_in,
    output iop_pad_t         segment_bidir_pad_b,
    input  wire logic [7:0]  segment_outputs_b
);

    iop_bus_st_t bus_st_reg, bus_st_next;
    logic [15:0] idx_reg, idx_next;
    logic [31:0] hrdata_reg, hrdata_next;
    logic [31:0] rd_mux;
    logic        accept;

    logic [7:0] first_latch_reg, first_latch_next, first_dir_reg, first_dir_next;
    logic [7:0] first_pu_reg, first_pu_next;
    logic [7:0] out_latch_reg, out_latch_next, out_tri_reg, out_tri_next;
    logic [7:0] sec_latch_reg, sec_latch_next, sec_dir_reg, sec_dir_next;
    logic [7:0] sec_pu_reg, sec_pu_next, sec_func_reg, sec_func_next;
    logic [7:0] sega_latch_reg, sega_latch_next, sega_dir_reg, sega_dir_next;
    logic [7:0] sega_pu_reg, sega_pu_next, sega_func_reg, sega_func_next;
    logic [7:0] segb_latch_reg, segb_latch_next, segb_dir_reg, segb_dir_next;
    logic [7:0] segb_pu_reg, segb_pu_next, disp_ctrl_reg, disp_ctrl_next;

    logic [3:0] level_reg, level_next, req_reg, req_next;
    logic       armed_reg, armed_next;
    iop_pad_t   first_w, second_w, sega_w, segb_w, out_w;
    iop_pad_t   first_pad_reg, second_pad_reg, sega_pad_reg, segb_pad_reg, out_pad_reg;
    logic [7:0] first_rd, second_rd, sega_rd, segb_rd;

    // Address phase is taken only when the bus is ready; hsize is always a word.
    assign accept = hsel & htrans[1] & hready;

    // Bus sequencing: reads insert one wait so a write just ahead is already stored.
    always_comb begin
        bus_st_next = bus_st_reg;
        idx_next    = idx_reg;
        hrdata_next = hrdata_reg;
        unique case (bus_st_reg)
            ST_IDLE, ST_WR, ST_RD_DONE: begin
                bus_st_next = ST_IDLE;
                if (accept) begin
                    idx_next    = haddr[ADDR_LSB +: 16];
                    bus_st_next = hwrite ? ST_WR : ST_RD_WAIT;
                end
            end
            ST_RD_WAIT: begin
                hrdata_next = rd_mux;
                bus_st_next = ST_RD_DONE;
            end
        endcase
    end

    always_ff @(posedge clk_sys) begin
        if (srst) begin
            bus_st_reg <= ST_IDLE;
            idx_reg    <= 16'h0000;
            hrdata_reg <= 32'h0000_0000;
        end else begin
            bus_st_reg <= bus_st_next;
            idx_reg    <= idx_next;
            hrdata_reg <= hrdata_next;
        end
    end

    assign hreadyout = (bus_st_reg != ST_RD_WAIT);
    assign hrdata    = hrdata_reg;
    assign hresp     = 1'b0;

    // Register writes in the data phase; absent pins keep their direction bit at one.
    always_comb begin
        first_latch_next = first_latch_reg;
        first_dir_next   = first_dir_reg;
        first_pu_next    = first_pu_reg;
        out_latch_next   = out_latch_reg;
        out_tri_next     = out_tri_reg;
        sec_latch_next   = sec_latch_reg;
        sec_dir_next     = sec_dir_reg;
        sec_pu_next      = sec_pu_reg;
        sec_func_next    = sec_func_reg;
        sega_latch_next  = sega_latch_reg;
        sega_dir_next    = sega_dir_reg;
        sega_pu_next     = sega_pu_reg;
        sega_func_next   = sega_func_reg;
        segb_latch_next  = segb_latch_reg;
        segb_dir_next    = segb_dir_reg;
        segb_pu_next     = segb_pu_reg;
        disp_ctrl_next   = disp_ctrl_reg;
        if (bus_st_reg == ST_WR) begin
            case (idx_reg)
                IDX_FIRST_DATA:  first_latch_next = hwdata[7:0] & FIRST_MASK; // see R23
                IDX_OUTPUT_DATA: out_latch_next   = hwdata[7:0]; // see R8
                IDX_SECOND_DATA: sec_latch_next   = hwdata[7:0] & SECOND_MASK; // see R23
                IDX_SEGA_DATA:   sega_latch_next  = hwdata[7:0];
                IDX_SEGB_DATA:   segb_latch_next  = hwdata[7:0];
                IDX_FIRST_DIR:   first_dir_next   = hwdata[7:0] | ~FIRST_MASK; // see R1
                IDX_OUT_TRI:     out_tri_next     = hwdata[7:0];
                IDX_SECOND_DIR:  sec_dir_next     = hwdata[7:0] | ~SECOND_MASK; // see R14
                IDX_SEGA_DIR:    sega_dir_next    = hwdata[7:0]; // see R17
                IDX_SEGB_DIR:    segb_dir_next    = hwdata[7:0];
                IDX_FIRST_PU:    first_pu_next    = hwdata[7:0] & FIRST_MASK;
                IDX_SECOND_PU:   sec_pu_next      = hwdata[7:0] & SECOND_MASK;
                IDX_SEGA_PU:     sega_pu_next     = hwdata[7:0];
                IDX_SEGB_PU:     segb_pu_next     = hwdata[7:0];
                IDX_SECOND_FUNC: sec_func_next    = hwdata[7:0] & SECOND_MASK;
                IDX_SEGA_FUNC:   sega_func_next   = hwdata[7:0];
                IDX_DISP_CTRL:   disp_ctrl_next   = hwdata[7:0];
                default: ; // Unmapped words ignore writes.
            endcase
        end
    end

    // Direction and tri-state registers come out of reset at all ones.
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            first_dir_reg   <= DIR_RST; // see R3 see R21
            out_tri_reg     <= DIR_RST; // see R9
            sec_dir_reg     <= DIR_RST; // see R15
            sega_dir_reg    <= DIR_RST; // see R17
            segb_dir_reg    <= DIR_RST; // see R19
            first_latch_reg <= LATCH_RST;
            out_latch_reg   <= LATCH_RST;
            sec_latch_reg   <= LATCH_RST;
            sega_latch_reg  <= LATCH_RST;
            segb_latch_reg  <= LATCH_RST;
            first_pu_reg    <= PU_RST;
            sec_pu_reg      <= PU_RST;
            sega_pu_reg     <= PU_RST;
            segb_pu_reg     <= PU_RST;
            sec_func_reg    <= FUNC_RST;
            sega_func_reg   <= FUNC_RST;
            disp_ctrl_reg   <= FUNC_RST;
        end else begin
            first_dir_reg   <= first_dir_next;
            out_tri_reg     <= out_tri_next;
            sec_dir_reg     <= sec_dir_next;
            sega_dir_reg    <= sega_dir_next;
            segb_dir_reg    <= segb_dir_next;
            first_latch_reg <= first_latch_next;
            out_latch_reg   <= out_latch_next;
            sec_latch_reg   <= sec_latch_next;
            sega_latch_reg  <= sega_latch_next;
            segb_latch_reg  <= segb_latch_next;
            first_pu_reg    <= first_pu_next;
            sec_pu_reg      <= sec_pu_next;
            sega_pu_reg     <= sega_pu_next;
            segb_pu_reg     <= segb_pu_next;
            sec_func_reg    <= sec_func_next;
            sega_func_reg   <= sega_func_next;
            disp_ctrl_reg   <= disp_ctrl_next;
        end
    end

    // Read value, sampled in the wait cycle; unmapped words read zero.
    always_comb begin
        rd_mux = 32'h0000_0000;
        case (idx_reg)
            IDX_FIRST_DATA:  rd_mux[7:0] = first_rd; // see R22
            IDX_INPUT_DATA:  rd_mux[4:0] = input_only_pins & INPUT_MASK; // see R7
            IDX_OUTPUT_DATA: rd_mux[7:0] = out_latch_reg & out_tri_reg; // see R10
            IDX_SECOND_DATA: rd_mux[7:0] = second_rd;
            IDX_SEGA_DATA:   rd_mux[7:0] = sega_rd;
            IDX_SEGB_DATA:   rd_mux[7:0] = segb_rd;
            IDX_FIRST_DIR:   rd_mux[7:0] = first_dir_reg;
            IDX_OUT_TRI:     rd_mux[7:0] = out_tri_reg;
            IDX_SECOND_DIR:  rd_mux[7:0] = sec_dir_reg;
            IDX_SEGA_DIR:    rd_mux[7:0] = sega_dir_reg;
            IDX_SEGB_DIR:    rd_mux[7:0] = segb_dir_reg;
            IDX_FIRST_PU:    rd_mux[7:0] = first_pu_reg;
            IDX_SECOND_PU:   rd_mux[7:0] = sec_pu_reg;
            IDX_SEGA_PU:     rd_mux[7:0] = sega_pu_reg;
            IDX_SEGB_PU:     rd_mux[7:0] = segb_pu_reg;
            IDX_SECOND_FUNC: rd_mux[7:0] = sec_func_reg;
            IDX_SEGA_FUNC:   rd_mux[7:0] = sega_func_reg;
            IDX_DISP_CTRL:   rd_mux[7:0] = disp_ctrl_reg;
            default:         rd_mux = 32'h0000_0000;
        endcase
    end

    // First port: no output alternate, no segment.
    iop_bidir_port #(.PIN_MASK(FIRST_MASK)) u_first (
        .latch   (first_latch_reg),
        .dir     (first_dir_reg),
        .pu_en   (first_pu_reg),
        .seg_sel (8'h00),
        .seg_val (8'h00),
        .alt_en  (8'h00),
        .alt_val (8'h00),
        .pin_in  (first_bidir_pins_in),
        .pad     (first_w),
        .rd_val  (first_rd)
    );

    // Second port: timer and serial outputs plus segments chosen by its function bits.
    iop_bidir_port #(.PIN_MASK(SECOND_MASK)) u_second (
        .latch   (sec_latch_reg),
        .dir     (sec_dir_reg),
        .pu_en   (sec_pu_reg),
        .seg_sel (sec_func_reg), // see R16
        .seg_val (segment_outputs_c),
        .alt_en  (second_alt_en), // see R13
        .alt_val (second_alt_val),
        .pin_in  (second_bidir_pins_in),
        .pad     (second_w),
        .rd_val  (second_rd)
    );

    // Port A: segment or I/O per pin from its function register.
    iop_bidir_port #(.PIN_MASK(FULL_MASK)) u_sega (
        .latch   (sega_latch_reg),
        .dir     (sega_dir_reg),
        .pu_en   (sega_pu_reg),
        .seg_sel (sega_func_reg), // see R18
        .seg_val (segment_outputs_a),
        .alt_en  (8'h00),
        .alt_val (8'h00),
        .pin_in  (segment_bidir_pins_a_in),
        .pad     (sega_w),
        .rd_val  (sega_rd)
    );

    // Port B: segment or I/O per pin from the display control register.
    iop_bidir_port #(.PIN_MASK(FULL_MASK)) u_segb (
        .latch   (segb_latch_reg),
        .dir     (segb_dir_reg),
        .pu_en   (segb_pu_reg),
        .seg_sel (disp_ctrl_reg), // see R19
        .seg_val (segment_outputs_b),
        .alt_en  (8'h00),
        .alt_val (8'h00),
        .pin_in  (segment_bidir_pins_b_in),
        .pad     (segb_w),
        .rd_val  (segb_rd)
    );

    // Output-only port: meter pulse-width ORed on the latch, mode bit one floats the pin.
    assign out_w = '{out: (out_latch_reg | (pwm_en & pwm_val)), // see R11
                     oe:  ~out_tri_reg, // see R8
                     pu:  8'h00};

    // Interrupt sense follows the pin level, which in output mode is the latch itself.
    // The first cycle after reset only loads the level, so a high pin raises no false request.
    always_comb begin
        armed_next = 1'b1;
        level_next = (first_dir_reg[3:0] & first_bidir_pins_in[3:0])
                   | (~first_dir_reg[3:0] & first_latch_reg[3:0]); // see R4
        req_next   = armed_reg ? (level_next ^ level_reg) : 4'h0; // see R5
    end

    // Pads are registered so every pin output comes from a flip-flop.
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            armed_reg      <= 1'b0;
            level_reg      <= 4'h0;
            req_reg        <= 4'h0;
            first_pad_reg  <= '0;
            second_pad_reg <= '0;
            sega_pad_reg   <= '0;
            segb_pad_reg   <= '0;
            out_pad_reg    <= '0;
        end else begin
            armed_reg      <= armed_next;
            level_reg      <= level_next;
            req_reg        <= req_next;
            first_pad_reg  <= first_w;
            second_pad_reg <= second_w;
            sega_pad_reg   <= sega_w;
            segb_pad_reg   <= segb_w;
            out_pad_reg    <= out_w;
        end
    end

    assign first_bidir_pad     = first_pad_reg;
    assign second_bidir_pad    = second_pad_reg;
    assign segment_bidir_pad_a = sega_pad_reg;
    assign segment_bidir_pad_b = segb_pad_reg;
    assign output_only_pad     = out_pad_reg;
    assign ext_int_level       = level_reg;
    assign ext_int_req         = req_reg; // see R6
    assign netc_ext_clk        = level_reg[NETC_CLK_BIT];

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (srst);

    sequence s_rd_of(logic [15:0] idx);
        bus_st_reg == ST_RD_WAIT && idx_reg == idx;
    endsequence

    sequence s_wr_first;
        accept && hwrite && haddr[ADDR_LSB +: 16] == IDX_FIRST_DATA;
    endsequence

    reset_dirs_a: assert property (disable iff (1'b0) // see R21
        $fell(srst) |-> first_dir_reg == 8'hFF && sec_dir_reg == 8'hFF
                        && out_tri_reg == 8'hFF && segb_dir_reg == 8'hFF)
        else $error("direction registers not all ones after reset");

    out_hiz_a: assert property ( // see R8
        out_tri_reg[0] |=> !output_only_pad.oe[0])
        else $error("output-only pin driven while its mode bit is one");

    out_readback_a: assert property ( // see R10
        s_rd_of(IDX_OUTPUT_DATA) |=>
            hrdata[7:0] == ($past(out_latch_reg) & $past(out_tri_reg)) && hreadyout)
        else $error("output port read-back wrong");

    int_request_a: assert property ( // see R5
        (!first_dir_reg[0] && $changed(first_latch_reg[0])) |=> ext_int_req[0])
        else $error("output level change raised no interrupt request");

    pullup_gate_a: assert property ( // see R2
        first_bidir_pad.pu[0] |-> $past(first_dir_reg[0]) && $past(first_pu_reg[0]))
        else $error("pull-up on while pin not in input mode");

    latch_write_a: assert property ( // see R23
        s_wr_first ##1 1'b1 |=> first_latch_reg == ($past(hwdata[7:0]) & FIRST_MASK))
        else $error("first port latch not updated by write");

    read_wait_a: assert property (
        (accept && !hwrite) |=> !hreadyout ##1 hreadyout)
        else $error("read wait state missing or too long");

    seg_select_a: assert property ( // see R18
        sega_func_reg[3] |=> segment_bidir_pad_a.oe[3]
                             && segment_bidir_pad_a.out[3] == $past(segment_outputs_a[3]))
        else $error("port A segment selection not honoured");

    input_read_a: assert property ( // see R7
        s_rd_of(IDX_INPUT_DATA) |=> hrdata == {27'h000_0000, $past(input_only_pins)})
        else $error("input-only port read wrong");

    bidir_read_a: assert property ( // see R22
        s_rd_of(IDX_SEGB_DATA) |=> hrdata[7:0] == (($past(segb_dir_reg)
            & $past(segment_bidir_pins_b_in)) | (~$past(segb_dir_reg) & $past(segb_latch_reg))))
        else $error("port B read does not follow direction");

endmodule

// *** iop_pin_model.sv ***
// Board-side model of one port's pads: resolves each pin level from the pad drive.
// Assumes the pad structure of the port group and one board level per pin.
`timescale 1ns/1ps
module iop_pin_model import iop_pkg::*; (
    // Pad drive and board level.
    input  wire iop_pad_t   pad,
    input  wire logic [7:0] ext,
    // Resolved level seen by the port.
    output logic [7:0]      pin
);
    // A driven pin shows the latch; a floating one shows its pull-up or the board level.
    always_comb begin
        pin = (pad.oe & pad.out) | (~pad.oe & (pad.pu | ext));
    end
endmodule

// *** iop_port_group_tb_top.sv ***
// Self-checking bench of the port group: AHB-Lite register traffic against bench expectations.
// Assumes one bus master and first-port pin levels resolved by the board model.
`timescale 1ns/1ps
module iop_port_group_tb_top import iop_pkg::*;;
    logic        clk_sys, srst, hsel, hwrite, hready, hreadyout, hresp, clr, nclk;
    logic [31:0] haddr, hwdata, hrdata, lf;
    logic [1:0]  htrans;
    logic [2:0]  hsize;
    logic [7:0]  ext, pin0, rd, pwm, seen, exp;
    logic [4:0]  in1;
    logic [3:0]  lvl, req;
    iop_pad_t    pad0, pad2, pad3, pada, padb;
    int          n_errors = 0;
    int          comparisons = 0;
    int          cyc = 0;
    logic [15:0] dirs [5] = '{IDX_FIRST_DIR, IDX_OUT_TRI, IDX_SECOND_DIR, IDX_SEGA_DIR, IDX_SEGB_DIR};

    iop_port_group dut (
        .clk_sys(clk_sys), .srst(srst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
        .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp),
        .first_bidir_pins_in(pin0), .first_bidir_pad(pad0), .ext_int_level(lvl),
        .ext_int_req(req), .netc_ext_clk(nclk), .input_only_pins(in1),
        .output_only_pad(pad2), .pwm_en(pwm), .pwm_val(pwm),
        .second_bidir_pins_in(ext), .second_bidir_pad(pad3), .second_alt_en(pwm),
        .second_alt_val(pwm), .segment_outputs_c(ext), .segment_bidir_pins_a_in(ext),
        .segment_bidir_pad_a(pada), .segment_outputs_a(ext), .segment_bidir_pins_b_in(ext),
        .segment_bidir_pad_b(padb), .segment_outputs_b(ext));
    iop_pin_model board0 (.pad(pad0), .ext(ext), .pin(pin0));
    assign hready = hreadyout;

    initial begin
        clk_sys = 1'b0;
        forever #4 clk_sys = ~clk_sys;
    end

    // Cycle ceiling cuts a hang short; request pulses are gathered so none is missed.
    always @(posedge clk_sys) begin
        cyc <= cyc + 1;
        seen <= clr ? 8'h00 : (seen | {4'h0, req});
        if (cyc == 5000) begin
            n_errors++;
            close_out();
        end
    end

    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction

    task automatic chk(input string what, input logic [7:0] e, input logic [7:0] got);
        comparisons++;
        if (got !== e) begin
            $display("wrong value %s expected %h seen %h", what, e, got);
            n_errors++;
        end
    endtask

    // One single AHB-Lite transfer; hready and read data are taken at the sampling edge.
    // Only the cycle ceiling ends a wait, so a stuck slave shows up as a failure.
    task automatic bus(input logic wr, input logic [15:0] idx, input logic [7:0] wd,
                       output logic [7:0] r);
        hsel <= 1'b1;
        htrans <= 2'b10;
        hwrite <= wr;
        haddr <= {14'h0, idx, 2'b00};
        do @(posedge clk_sys); while (hready !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'b00;
        hwdata <= {24'h0, wd};
        do @(posedge clk_sys); while (hready !== 1'b1);
        r = hrdata[7:0];
        chk("hresp", 8'h00, {7'h0, hresp});
    endtask

    task automatic close_out();
        $display("errors %0d comparisons %0d", n_errors, comparisons);
        if (n_errors == 0 && comparisons > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask

    // Alternate sources stay off so every pin outside segment use drives its latch.
    initial begin
        {hsel, hwrite, htrans, haddr, hwdata, pwm, clr} = '0;
        hsize = 3'b010;
        srst = 1'b1;
        ext = 8'hA5;
        in1 = 5'h0A;
        lf = 32'h7445_1756;
        repeat (6) @(posedge clk_sys);
        srst <= 1'b0;
        @(posedge clk_sys);
        chk("pad oe", 8'h00, pad0.oe | pad2.oe | pad3.oe | pada.oe | padb.oe);
        foreach (dirs[i]) begin
            bus(1'b0, dirs[i], 8'h00, rd);
            chk("direction reset", DIR_RST, rd);
        end
        // Random latch, direction and pull-up settings, latch written before the direction.
        for (int i = 0; i < 8; i++) begin
            lf = lfsr(lf);
            ext <= lf[7:0];
            in1 <= lf[24:20];
            bus(1'b1, IDX_FIRST_DATA, {4'h0, lf[11:8]}, rd);
            bus(1'b1, IDX_FIRST_DIR, {4'hF, lf[15:12]}, rd);
            bus(1'b1, IDX_FIRST_PU, {4'h0, lf[19:16]}, rd);
            bus(1'b1, IDX_OUTPUT_DATA, lf[31:24], rd);
            bus(1'b1, IDX_OUT_TRI, lf[7:0], rd);
            repeat (2) @(posedge clk_sys);
            exp = {4'h0, (lf[15:12] & (lf[19:16] | lf[3:0])) | (~lf[15:12] & lf[11:8])};
            bus(1'b0, IDX_FIRST_DATA, 8'h00, rd);
            chk("first data", exp, rd);
            chk("first oe", {4'h0, ~lf[15:12]}, pad0.oe);
            chk("first pu", {4'h0, lf[15:12] & lf[19:16]}, pad0.pu);
            bus(1'b0, IDX_INPUT_DATA, 8'h00, rd);
            chk("input data", {3'h0, lf[24:20]}, rd);
            bus(1'b0, IDX_OUTPUT_DATA, 8'h00, rd);
            chk("output read", lf[31:24] & lf[7:0], rd);
            chk("output oe", ~lf[7:0], pad2.oe);
            chk("output out", lf[31:24], pad2.out);
        end
        // A level change on a driven first-port pin raises its request; nothing masks it here.
        bus(1'b1, IDX_FIRST_DIR, 8'hFE, rd);
        bus(1'b1, IDX_FIRST_DATA, 8'h00, rd);
        repeat (3) @(posedge clk_sys);
        clr <= 1'b1;
        @(posedge clk_sys);
        clr <= 1'b0;
        bus(1'b1, IDX_FIRST_DATA, 8'h01, rd);
        repeat (3) @(posedge clk_sys);
        chk("interrupt request", 8'h01, seen);
        chk("interrupt level", 8'h01, {7'h0, lvl[0]});
        chk("network clock", 8'h01, {7'h0, nclk});
        // Segment use: function bits are set before the segment sources are relied on.
        bus(1'b1, IDX_SECOND_FUNC, 8'hF0, rd);
        bus(1'b1, IDX_SEGA_FUNC, 8'h0F, rd);
        bus(1'b1, IDX_SEGB_DIR, 8'h0F, rd);
        bus(1'b1, IDX_SEGB_DATA, 8'h3C, rd);
        bus(1'b1, IDX_DISP_CTRL, 8'h01, rd);
        bus(1'b0, IDX_SEGB_DATA, 8'h00, rd);
        chk("port B data", (ext & 8'h0F) | 8'h30, rd);
        chk("port B oe", 8'hF1, padb.oe);
        chk("second oe", 8'hF0, pad3.oe);
        chk("second out", ext & 8'hF0, pad3.out & pad3.oe);
        chk("port A oe", 8'h0F, pada.oe);
        chk("port A out", ext & 8'h0F, pada.out & 8'h0F);
        bus(1'b0, 16'hFF7F, 8'h00, rd);
        chk("unmapped read", 8'h00, rd);
        close_out();
    end
endmodule
